/* File: inc/pfs_regs.svh */
`ifndef PFS_REGS_SVH
`define PFS_REGS_SVH

// ----------------------------------------------------------------
// clock
// ----------------------------------------------------------------
`define PFS_CLK_MHZ 25
`define PFS_CLK_KHZ 25000

// ----------------------------------------------------------------
// times in their own units
// ----------------------------------------------------------------
`define PFS_CAP_LONG_NS 2000
`define PFS_CAP_SHORT_NS 1000
`define PFS_SETTLE_NS 10000
`define PFS_RECOVERY_MS 1500

// ----------------------------------------------------------------
// cycle counts
// ----------------------------------------------------------------
`define PFS_CAP_LONG_CYC ((`PFS_CAP_LONG_NS * `PFS_CLK_MHZ) / 1000)
`define PFS_CAP_SHORT_CYC ((`PFS_CAP_SHORT_NS * `PFS_CLK_MHZ) / 1000)
`define PFS_SETTLE_CYC ((`PFS_SETTLE_NS * `PFS_CLK_MHZ + 999) / 1000)
`define PFS_RECOVERY_CYC (`PFS_RECOVERY_MS * `PFS_CLK_KHZ)

// ----------------------------------------------------------------
// widths and counts
// ----------------------------------------------------------------
`define PFS_TMR_W 26
`define PFS_STRIKES 2'h3
`define PFS_NSYNC 12

`endif

/* File: inc/pfs_pkg.sv */
package pfs_pkg;

  // ----------------------------------------------------------------
  // supervisor states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE      = 3'b000,
    ST_SETTLE    = 3'b001,
    ST_WAIT_BIAS = 3'b010,
    ST_FIRST     = 3'b011,
    ST_RUN       = 3'b100,
    ST_LOCKOUT   = 3'b101,
    ST_RECOVER   = 3'b110,
    ST_REARM     = 3'b111
  } pfs_state_t;

  typedef logic [1:0] pfs_strike_t;

endpackage : pfs_pkg

/* File: core/pfs_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pfs_regs.svh"

module pfs_timer (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic load_i,
  input wire logic [`PFS_TMR_W-1:0] load_val_i,
  output logic done_o
);

  logic [`PFS_TMR_W-1:0] cnt_ff;

  // ----------------------------------------------------------------
  // down counter, done after load_val cycles
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_ff <= '0;
    end else if (load_i) begin
      cnt_ff <= load_val_i;
    end else if (cnt_ff != '0) begin
      cnt_ff <= cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      done_o <= 1'b0;
    end else if (load_i) begin
      done_o <= 1'b0;
    end else begin
      done_o <= (cnt_ff <= `PFS_TMR_W'(1));
    end
  end

endmodule : pfs_timer
`default_nettype wire

/* File: core/pfs_supervisor.sv */
// What this block does
// - time only first gate pulse after startup
// - 5 V select: 2 us cap, recovery
// - 0 V select: cap from demag resistor
// - three consecutive overcurrent pulses: stop, start recovery
// - no pulses until bias pin regulates
// - bias below 14 V after delay: lockout
// - three consecutive bias over-voltage pulses: lockout cycle, unless the third overcurrent strike ends the same pulse
// - drive programming pins, flag any open/short as one fault
// - programming pin fault: lockout, retry next
// - recovery done, supply off: restart
`timescale 1ns/1ps
`default_nettype none
`include "pfs_regs.svh"

module pfs_supervisor
  import pfs_pkg::*;
#(
  parameter logic [`PFS_TMR_W-1:0] RECOVERY_CYCLES =
    `PFS_TMR_W'(`PFS_RECOVERY_CYC)
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic gate_pulse_i,
  input wire logic vdd_on_i,
  input wire logic vdd_off_i,
  input wire logic cs_over_limit_i,
  input wire logic bias_below_14_i,
  input wire logic bias_above_15_i,
  input wire logic bias_in_reg_i,
  input wire logic stage_sel_5v_i,
  input wire logic demag_above_th_i,
  input wire logic demag_pin_open_i,
  input wire logic demag_pin_short_i,
  input wire logic zvs_pin_open_i,
  input wire logic zvs_pin_short_i,
  output logic switch_inhibit_o,
  output logic lockout_req_o,
  output logic recovery_active_o,
  output logic pin_drive_o,
  output logic fault_cs_short_o,
  output logic fault_cs_open_o,
  output logic fault_bias_open_o,
  output logic fault_bias_ov_o,
  output logic fault_prog_pin_o
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [`PFS_NSYNC-1:0] s1_ff;
  logic [`PFS_NSYNC-1:0] s2_ff;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_ff <= '0;
      s2_ff <= '0;
    end else begin
      s1_ff <= {vdd_on_i, vdd_off_i, cs_over_limit_i, bias_below_14_i,
                bias_above_15_i, bias_in_reg_i, stage_sel_5v_i,
                demag_above_th_i, demag_pin_open_i, demag_pin_short_i,
                zvs_pin_open_i, zvs_pin_short_i};
      s2_ff <= s1_ff;
    end
  end

  logic vdd_on_s, vdd_off_s, oc_s, lt14_s, gt15_s, inreg_s;
  logic sel5_s, demag_hi_s, prog_bad_s;
  assign vdd_on_s = s2_ff[11];
  assign vdd_off_s = s2_ff[10];
  assign oc_s = s2_ff[9];
  assign lt14_s = s2_ff[8];
  assign gt15_s = s2_ff[7];
  assign inreg_s = s2_ff[6];
  assign sel5_s = s2_ff[5];
  assign demag_hi_s = s2_ff[4];
  assign prog_bad_s = |s2_ff[3:0];

  // ----------------------------------------------------------------
  // edges and strike counting
  // ----------------------------------------------------------------
  function automatic pfs_strike_t strike_next(input pfs_strike_t cnt,
                                              input logic hit);
    if (!hit) begin
      strike_next = 2'h0;
    end else if (cnt == `PFS_STRIKES) begin
      strike_next = cnt;
    end else begin
      strike_next = cnt + 2'h1;
    end
  endfunction : strike_next

  logic gate_d_ff, vdd_on_d_ff;
  logic oc_hit_ff, ov_hit_ff;
  pfs_strike_t oc_cnt_ff, ov_cnt_ff;
  logic pulse_rise, pulse_end, start_evt;

  assign pulse_rise = gate_pulse_i & ~gate_d_ff;
  assign pulse_end = gate_d_ff & ~gate_pulse_i;
  assign start_evt = vdd_on_s & ~vdd_on_d_ff;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      gate_d_ff <= 1'b0;
      vdd_on_d_ff <= 1'b0;
    end else begin
      gate_d_ff <= gate_pulse_i;
      vdd_on_d_ff <= vdd_on_s;
    end
  end

  pfs_state_t state_ff, nxt_state;
  logic in_run;
  assign in_run = (state_ff == ST_RUN);

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      oc_hit_ff <= 1'b0;
      ov_hit_ff <= 1'b0;
    end else if (pulse_end || !in_run) begin
      oc_hit_ff <= 1'b0;
      ov_hit_ff <= 1'b0;
    end else if (gate_pulse_i) begin
      oc_hit_ff <= oc_hit_ff | oc_s;
      ov_hit_ff <= ov_hit_ff | gt15_s;
    end
  end

  pfs_strike_t nxt_oc_cnt, nxt_ov_cnt;
  assign nxt_oc_cnt = strike_next(oc_cnt_ff, oc_hit_ff);
  assign nxt_ov_cnt = strike_next(ov_cnt_ff, ov_hit_ff);

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      oc_cnt_ff <= 2'h0;
      ov_cnt_ff <= 2'h0;
    end else if (!in_run) begin
      oc_cnt_ff <= 2'h0;
      ov_cnt_ff <= 2'h0;
    end else if (pulse_end) begin
      oc_cnt_ff <= nxt_oc_cnt;
      ov_cnt_ff <= nxt_ov_cnt;
    end
  end

  logic open_trip, ov_trip;
  assign open_trip = in_run & pulse_end
                     & (nxt_oc_cnt == `PFS_STRIKES);
  assign ov_trip = in_run & pulse_end & (nxt_ov_cnt == `PFS_STRIKES);

  // ----------------------------------------------------------------
  // shared timer
  // ----------------------------------------------------------------
  logic tmr_load, tmr_done;
  logic [`PFS_TMR_W-1:0] tmr_val;
  logic cap_hit;

  pfs_timer u_timer (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .load_i(tmr_load),
    .load_val_i(tmr_val),
    .done_o(tmr_done)
  );

  assign cap_hit = (state_ff == ST_FIRST) & gate_pulse_i & gate_d_ff
                   & tmr_done;

  always_comb begin
    tmr_load = 1'b0;
    tmr_val = `PFS_TMR_W'(`PFS_SETTLE_CYC);
    if (state_ff == ST_IDLE && start_evt) begin
      tmr_load = 1'b1;
    end else if (state_ff == ST_FIRST && pulse_rise) begin
      tmr_load = 1'b1;
      if (sel5_s || demag_hi_s) begin
        tmr_val = `PFS_TMR_W'(`PFS_CAP_LONG_CYC);
      end else begin
        tmr_val = `PFS_TMR_W'(`PFS_CAP_SHORT_CYC);
      end
    end else if (nxt_state == ST_RECOVER && state_ff != ST_RECOVER) begin
      tmr_load = 1'b1;
      tmr_val = RECOVERY_CYCLES;
    end
  end

  // ----------------------------------------------------------------
  // sequence control
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (start_evt) nxt_state = ST_SETTLE;
      end
      ST_SETTLE: begin
        if (tmr_done) begin
          if (prog_bad_s || lt14_s) begin
            nxt_state = ST_LOCKOUT;
          end else begin
            nxt_state = ST_WAIT_BIAS;
          end
        end
      end
      ST_WAIT_BIAS: begin
        if (inreg_s) nxt_state = ST_FIRST;
      end
      ST_FIRST: begin
        if (cap_hit) begin
          nxt_state = ST_RECOVER;
        end else if (pulse_end) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (open_trip) begin
          nxt_state = ST_RECOVER;
        end else if (ov_trip) begin
          nxt_state = ST_LOCKOUT;
        end
      end
      ST_LOCKOUT: begin
        if (vdd_off_s) nxt_state = ST_IDLE;
      end
      ST_RECOVER: begin
        if (tmr_done) nxt_state = ST_REARM;
      end
      ST_REARM: begin
        if (vdd_off_s) nxt_state = ST_IDLE;
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      switch_inhibit_o <= 1'b1;
      lockout_req_o <= 1'b0;
      recovery_active_o <= 1'b0;
      pin_drive_o <= 1'b0;
    end else begin
      switch_inhibit_o <= !(nxt_state == ST_FIRST
                            || nxt_state == ST_RUN);
      lockout_req_o <= (nxt_state == ST_LOCKOUT);
      recovery_active_o <= (nxt_state == ST_RECOVER);
      pin_drive_o <= (nxt_state == ST_SETTLE);
    end
  end

  logic clr_faults;
  assign clr_faults = (state_ff == ST_IDLE) & start_evt;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fault_cs_short_o <= 1'b0;
      fault_cs_open_o <= 1'b0;
      fault_bias_open_o <= 1'b0;
      fault_bias_ov_o <= 1'b0;
      fault_prog_pin_o <= 1'b0;
    end else if (clr_faults) begin
      fault_cs_short_o <= 1'b0;
      fault_cs_open_o <= 1'b0;
      fault_bias_open_o <= 1'b0;
      fault_bias_ov_o <= 1'b0;
      fault_prog_pin_o <= 1'b0;
    end else begin
      if (cap_hit) fault_cs_short_o <= 1'b1;
      if (open_trip) fault_cs_open_o <= 1'b1;
      if (ov_trip && !open_trip) fault_bias_ov_o <= 1'b1;
      if (state_ff == ST_SETTLE && tmr_done) begin
        if (lt14_s) fault_bias_open_o <= 1'b1;
        if (prog_bad_s) fault_prog_pin_o <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence seq_first_cut;
    (state_ff == ST_FIRST) ##1 $rose(fault_cs_short_o);
  endsequence

  sequence seq_settle_fail;
    (state_ff == ST_SETTLE) ##1 (state_ff == ST_LOCKOUT);
  endsequence

  a_first_only: assert property (@(posedge clock_i) disable iff (!nrst_i)
    $rose(fault_cs_short_o) |-> $past(state_ff) == ST_FIRST)
    else $error("short fault outside first pulse");

  a_cap_recover: assert property (@(posedge clock_i) disable iff (!nrst_i)
    seq_first_cut |-> recovery_active_o && switch_inhibit_o)
    else $error("short fault without recovery");

  a_cap_short: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (state_ff == ST_FIRST && pulse_rise && !sel5_s && !demag_hi_s)
    ##1 (gate_pulse_i && state_ff == ST_FIRST) [*8]
    |-> !fault_cs_short_o)
    else $error("short cap tripped too early");

  a_open_three: assert property (@(posedge clock_i) disable iff (!nrst_i)
    $rose(fault_cs_open_o) |-> $past(oc_cnt_ff) == 2'h2
    && recovery_active_o)
    else $error("open fault without three strikes");

  a_bias_wait: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (state_ff == ST_WAIT_BIAS) |-> switch_inhibit_o)
    else $error("pulses before bias regulation");

  a_bias_open: assert property (@(posedge clock_i) disable iff (!nrst_i)
    $rose(fault_bias_open_o) |-> lockout_req_o
    && $past(state_ff) == ST_SETTLE)
    else $error("bias open without lockout");

  a_ov_three: assert property (@(posedge clock_i) disable iff (!nrst_i)
    $rose(fault_bias_ov_o) |-> $past(ov_cnt_ff) == 2'h2
    && lockout_req_o)
    else $error("over-voltage without three strikes");

  a_pin_drive: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (state_ff == ST_SETTLE) |-> pin_drive_o && switch_inhibit_o)
    else $error("programming pins not driven");

  a_pin_lockout: assert property (@(posedge clock_i) disable iff (!nrst_i)
    seq_settle_fail |-> lockout_req_o
    && (fault_prog_pin_o || fault_bias_open_o))
    else $error("pin fault without lockout");

  a_rearm_wait: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (state_ff == ST_REARM && !vdd_off_s) |=> state_ff == ST_REARM)
    else $error("restart before supply off");

  a_strike_clear: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (in_run && pulse_end && !oc_hit_ff) |=> oc_cnt_ff == 2'h0)
    else $error("strike count not cleared");

  a_no_pulse: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (recovery_active_o || lockout_req_o) |-> switch_inhibit_o)
    else $error("switching during fault");

endmodule : pfs_supervisor
`default_nettype wire

/* File: tb/pfs_stage_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// gate drive of the power stage
// ----------------------------------------
module pfs_stage_model (
  input wire logic clock_i,
  input wire logic inhibit_i,
  input wire logic fire_i,
  input wire logic [7:0] width_i,
  output logic gate_o
);
  int cnt;
  logic req;

  initial begin
    gate_o = 1'h0;
    cnt = 0;
    req = 1'h0;
  end

  // request taken on the rising edge, clear of the bench's own edge
  always @(posedge clock_i) begin
    req <= fire_i;
  end

  // one pulse a request; cut short once switching is inhibited
  always @(negedge clock_i) begin
    if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 1 || inhibit_i) begin
        gate_o <= 1'h0;
        cnt <= 0;
      end
    end else if (req && !inhibit_i) begin
      gate_o <= 1'h1;
      cnt <= width_i;
    end
  end
endmodule : pfs_stage_model

`default_nettype wire

/* File: tb/pin_fault_supervisor_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module pin_fault_supervisor_bench;
  import pfs_pkg::*;
  localparam int REC = 100;
  logic clock_i = 1'h0;
  logic nrst_i = 1'h0;
  logic gate_pulse, fire, vdd_on, vdd_off, cs_over, b14, b15, in_reg;
  logic sel, dem, dm_open, dm_short, zv_open, zv_short;
  logic inh, lock, recov, drive, f_short, f_open, f_bopen, f_ov, f_prog;
  logic [7:0] width;
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  int w;
  int cap;

  always #20 clock_i = ~clock_i;

  pfs_stage_model u_pfs_stage_model (.clock_i(clock_i), .inhibit_i(inh),
    .fire_i(fire), .width_i(width), .gate_o(gate_pulse));

  pfs_supervisor #(.RECOVERY_CYCLES(26'(REC))) u_pfs_supervisor (
    .clock_i(clock_i), .nrst_i(nrst_i), .gate_pulse_i(gate_pulse),
    .vdd_on_i(vdd_on), .vdd_off_i(vdd_off), .cs_over_limit_i(cs_over),
    .bias_below_14_i(b14), .bias_above_15_i(b15), .bias_in_reg_i(in_reg),
    .stage_sel_5v_i(sel), .demag_above_th_i(dem),
    .demag_pin_open_i(dm_open), .demag_pin_short_i(dm_short),
    .zvs_pin_open_i(zv_open), .zvs_pin_short_i(zv_short),
    .switch_inhibit_o(inh), .lockout_req_o(lock),
    .recovery_active_o(recov), .pin_drive_o(drive),
    .fault_cs_short_o(f_short), .fault_cs_open_o(f_open),
    .fault_bias_open_o(f_bopen), .fault_bias_ov_o(f_ov),
    .fault_prog_pin_o(f_prog));

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task complete_run();
    if (failures == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      complete_run();
    end
  end

  // ----------------------------------------
  // stimulus tasks
  // ----------------------------------------
  task do_reset();
    @(negedge clock_i);
    nrst_i = 1'h0;
    repeat (6) @(negedge clock_i);
    nrst_i = 1'h1;
    check(inh, 1'h1);
  endtask : do_reset

  task end_cycle();
    vdd_off = 1'h1;
    repeat (5) @(negedge clock_i);
    vdd_off = 1'h0;
    repeat (2) @(negedge clock_i);
    check(lock, 1'h0);
  endtask : end_cycle

  // supply stays up through recovery; a start attempt is ignored
  task recover_end();
    repeat (50) @(negedge clock_i);
    check(recov, 1'h1);
    repeat (80) @(negedge clock_i);
    check(recov, 1'h0);
    check(inh, 1'h1);
    vdd_on = 1'h1;
    repeat (6) @(negedge clock_i);
    check(drive, 1'h0);
    vdd_on = 1'h0;
    end_cycle();
  endtask : recover_end

  task start_up(input logic s, input logic d, input logic lo,
                input logic [3:0] pf);
    @(negedge clock_i);
    sel = s;
    dem = d;
    b14 = lo;
    {dm_open, dm_short, zv_open, zv_short} = pf;
    in_reg = 1'h0;
    vdd_on = 1'h1;
    repeat (4) @(negedge clock_i);
    check(drive, 1'h1);
    repeat (270) @(negedge clock_i);
    check(drive, 1'h0);
    check(inh, 1'h1);
    check(f_bopen, lo);
    check(f_prog, |pf);
    check(lock, lo | (|pf));
    vdd_on = 1'h0;
    if (lo || pf != 4'h0) begin
      end_cycle();
    end else begin
      in_reg = 1'h1;
      repeat (4) @(negedge clock_i);
      check(inh, 1'h0);
    end
  endtask : start_up

  task pulse(input int pw, input logic oc, input logic ov);
    @(negedge clock_i);
    width = 8'(pw);
    cs_over = oc;
    b15 = ov;
    fire = 1'h1;
    @(negedge clock_i);
    fire = 1'h0;
    repeat (pw + 4) @(negedge clock_i);
    cs_over = 1'h0;
    b15 = 1'h0;
    repeat (2) @(negedge clock_i);
  endtask : pulse

  // strike pattern, first pulse in bit 0; bench keeps its own count
  task strikes(input logic is_oc);
    int run;
    logic [5:0] pat;
    run = 0;
    pat = 6'b11_1011;
    for (int k = 0; k < 6; k++) begin
      pulse(20, is_oc & pat[k], !is_oc & pat[k]);
      run = pat[k] ? run + 1 : 0;
      if (is_oc) begin
        check(f_open, 1'(run >= 3));
        check(recov, 1'(run >= 3));
      end else begin
        check(f_ov, 1'(run >= 3));
        check(lock, 1'(run >= 3));
      end
    end
    check(inh, 1'h1);
  endtask : strikes

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {fire, vdd_on, vdd_off, cs_over, b14, b15, in_reg} = '0;
    {sel, dem, dm_open, dm_short, zv_open, zv_short} = '0;
    width = 8'h00;
    void'($urandom(43264));
    do_reset();
    start_up(1'h1, 1'h0, 1'h1, 4'h0);
    for (int k = 0; k < 4; k++) begin
      start_up(1'h0, 1'h1, 1'h0, 4'(1 << k));
    end
    for (int i = 0; i < 8; i++) begin
      start_up(i[0], i[1], 1'h0, 4'h0);
      cap = (i[0] | i[1]) ? 50 : 25;
      w = i[2] ? cap + 6 + $urandom % 10 : cap - 6 - $urandom % 10;
      pulse(w, 1'h0, 1'h0);
      check(f_short, i[2]);
      check(recov, i[2]);
      check(inh, i[2]);
      if (i[2]) begin
        recover_end();
      end else begin
        pulse(60, 1'h0, 1'h0);
        check(f_short, 1'h0);
        if (i == 0) begin
          strikes(1'h1);
          recover_end();
        end else if (i == 1) begin
          strikes(1'h0);
          end_cycle();
        end else begin
          do_reset();
        end
      end
    end
    complete_run();
  end
endmodule : pin_fault_supervisor_bench

`default_nettype wire
